//--- logic/solenoid_regs_pkg.sv
// Package: register map, field layout, timing and carrier types of the register bank
package solenoid_regs_pkg;

    // ------------------------------------------------------------
    // Register map and serial frame layout
    // ------------------------------------------------------------
    localparam logic [3:0] STATUS_ADDR = 4'h0;
    localparam logic [3:0] CFG_FIRST_ADDR = 4'h1;
    localparam logic [3:0] CFG_LAST_ADDR = 4'h8;
    localparam int NUM_CH = 8;
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 32;
    localparam logic [5:0] CMD_DONE_CNT = 6'h08;
    localparam logic [5:0] FRAME_BITS = 6'h28;
    localparam int CMD_WRITE_POS = 7;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ON_LSB = 24;
    localparam int PAIR23_LSB = 10;
    localparam int PAIR01_LSB = 8;
    localparam int THERMAL_POS = 7;
    localparam int OVERCURRENT_POS = 6;
    localparam int OPEN_LOAD_POS = 5;
    localparam int EXCITE_MISS_POS = 4;
    localparam int PLUNGER_POS = 3;
    localparam int COMM_ERR_POS = 2;
    localparam int UNDERVOLT_POS = 1;
    localparam int ACTIVE_POS = 0;
    localparam logic UNDERVOLT_RESET = 1'b1;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Pair modes, bridge states, excitation coding
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_INDEP = 2'h0;
    localparam logic [1:0] MODE_PARALLEL = 2'h1;
    localparam logic [1:0] MODE_HBRIDGE = 2'h2;
    localparam logic [1:0] BRIDGE_HIZ = 2'h0;
    localparam logic [7:0] HIT_NONE = 8'h00;
    localparam logic [7:0] HIT_CONTINUOUS = 8'hFF;
    localparam int HIT_PERIODS_PER_LSB = 40;

    // ------------------------------------------------------------
    // Timing: main oscillator derived from the system clock
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int MAIN_OSC_FREQ_HZ = 100_000;
    localparam int OSC_DIV_CYCLES = CLK_FREQ_HZ / MAIN_OSC_FREQ_HZ;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scale_half_select;
        logic [6:0] hold_level;
        logic pin_or_serial_select;
        logic [6:0] hit_level;
        logic [7:0] hit_time;
        logic regulation_select;
        logic side_select;
        logic [1:0] chop_divider;
        logic slew_limit_enable;
        logic open_load_check_enable;
        logic plunger_check_enable;
        logic excite_check_enable;
    } chan_cfg_type;

    typedef struct packed {
        logic [NUM_CH-1:0] overcurrent;
        logic [NUM_CH-1:0] open_load;
        logic [NUM_CH-1:0] excite_miss;
        logic [NUM_CH-1:0] plunger;
    } chan_fault_type;

endpackage : solenoid_regs_pkg

//--- logic/solenoid_driver_status_config_regs.sv
// Status/config register bank of the eight-channel solenoid driver with its serial port
`timescale 1ns/10ps
module solenoid_driver_status_config_regs #(
    parameter int HIT_CNT_W = 14
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    input wire logic thermal_i,
    input wire logic undervolt_event_i,
    input wire solenoid_regs_pkg::chan_fault_type fault_i,
    output logic [solenoid_regs_pkg::NUM_CH-1:0] drive_on_o,
    output logic [solenoid_regs_pkg::NUM_CH-1:0] excite_o,
    output logic [solenoid_regs_pkg::NUM_CH-1:0] chop_tick_o,
    output logic [1:0] bridge01_o,
    output logic [1:0] bridge23_o,
    output solenoid_regs_pkg::chan_cfg_type [solenoid_regs_pkg::NUM_CH-1:0] drive_cfg_o
);
    import solenoid_regs_pkg::*;

    // Longest excitation is 254 x 40 chop periods; refused at elaboration
    if (HIT_CNT_W < 14 || HIT_CNT_W > 31) begin : g_bad_hit_width
        $error("HIT_CNT_W must hold 254 x 40 and stay below 32 bits");
    end

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    logic sclk_q;
    logic cs_n_q;
    logic rise_q;
    logic [5:0] bit_cnt_q;
    logic [CMD_BITS-1:0] cmd_q;
    logic [DATA_BITS-1:0] wdata_q;
    logic [DATA_BITS-1:0] rd_shift_q;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    logic rd_load;
    logic is_write;
    logic addr_ok;
    logic wr_commit;
    logic wr_error;
    logic [3:0] addr;

    // Edge detection; pins are already synchronous to clk_i
    assign sclk_rise = sclk_i & ~sclk_q & ~cs_n_i;
    assign sclk_fall = ~sclk_i & sclk_q & ~cs_n_i;
    assign frame_end = cs_n_i & ~cs_n_q;
    assign addr = cmd_q[3:0];
    assign is_write = cmd_q[CMD_WRITE_POS];
    assign addr_ok = addr <= CFG_LAST_ADDR;
    assign rd_load = rise_q && (bit_cnt_q == CMD_DONE_CNT);
    assign wr_commit = frame_end && is_write && (bit_cnt_q == FRAME_BITS) && addr_ok;
    // A write frame of the wrong length or to no register is a fault
    assign wr_error = frame_end && is_write && (bit_cnt_q >= CMD_DONE_CNT) &&
        ((bit_cnt_q != FRAME_BITS) || !addr_ok);

    // Edge history
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            rise_q <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
            cs_n_q <= cs_n_i;
            rise_q <= sclk_rise;
        end
    end

    // Command and write data capture, MSB first on rising SCLK
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt_q <= 6'h00;
            cmd_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
        end else if (cs_n_i) begin
            if (!frame_end) begin
                bit_cnt_q <= 6'h00;
            end
        end else if (sclk_rise) begin
            if (bit_cnt_q < CMD_DONE_CNT) begin
                cmd_q <= {cmd_q[CMD_BITS-2:0], mosi_i};
            end else begin
                wdata_q <= {wdata_q[DATA_BITS-2:0], mosi_i};
            end
            // Saturate so an overlong frame never wraps into a valid length
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    chan_cfg_type [NUM_CH-1:0] cfg_q;
    logic [NUM_CH-1:0] channel_on_q;
    logic [1:0] pair01_q;
    logic [1:0] pair23_q;
    logic active_q;
    logic comm_error_q;
    logic undervoltage_q;
    logic [7:1] flags_q;
    logic [DATA_BITS-1:0] status_rd;
    logic [DATA_BITS-1:0] rd_mux;
    logic [NUM_CH-1:0] excite_miss_cdr;

    // Channel configuration registers, one per address
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= {NUM_CH{CFG_RESET}};
        end else if (wr_commit && addr >= CFG_FIRST_ADDR) begin
            cfg_q[3'(addr - CFG_FIRST_ADDR)] <= wdata_q;
        end
    end

    // Status control fields; mode change only with the pair switched off
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            channel_on_q <= 8'h00;
            pair01_q <= MODE_INDEP;
            pair23_q <= MODE_INDEP;
            active_q <= 1'b0;
        end else if (wr_commit && addr == STATUS_ADDR) begin
            channel_on_q <= wdata_q[ON_LSB +: NUM_CH];
            active_q <= wdata_q[ACTIVE_POS];
            if (channel_on_q[1:0] == 2'b00) begin
                pair01_q <= wdata_q[PAIR01_LSB +: 2];
            end
            if (channel_on_q[3:2] == 2'b00) begin
                pair23_q <= wdata_q[PAIR23_LSB +: 2];
            end
        end
    end

    // Excitation miss only counts on current-regulated channels
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            excite_miss_cdr[i] = fault_i.excite_miss[i] &
                ~cfg_q[i].regulation_select;
        end
    end

    // Chip-level flags sampled from thermal_i and the per-channel fault lines
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_q <= 7'h00;
        end else begin
            flags_q[THERMAL_POS] <= thermal_i;
            flags_q[OVERCURRENT_POS] <= |fault_i.overcurrent;
            flags_q[OPEN_LOAD_POS] <= |fault_i.open_load;
            flags_q[EXCITE_MISS_POS] <= |excite_miss_cdr;
            flags_q[PLUNGER_POS] <= |fault_i.plunger;
            flags_q[COMM_ERR_POS] <= 1'b0;
            flags_q[UNDERVOLT_POS] <= 1'b0;
        end
    end

    // Sticky event flags, cleared when status is read; a new event wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            comm_error_q <= 1'b0;
            undervoltage_q <= UNDERVOLT_RESET;
        end else begin
            if (wr_error) begin
                comm_error_q <= 1'b1;
            end else if (rd_load && addr == STATUS_ADDR) begin
                comm_error_q <= 1'b0;
            end
            if (undervolt_event_i) begin
                undervoltage_q <= 1'b1;
            end else if (rd_load && addr == STATUS_ADDR) begin
                undervoltage_q <= 1'b0;
            end
        end
    end

    // Read data; unmapped addresses read as zero
    always_comb begin
        status_rd = {channel_on_q, 12'h000, pair23_q, pair01_q,
            flags_q[7:3], comm_error_q, undervoltage_q, active_q};
        rd_mux = 32'h0000_0000;
        if (addr == STATUS_ADDR) begin
            rd_mux = status_rd;
        end else if (addr_ok) begin
            rd_mux = cfg_q[3'(addr - CFG_FIRST_ADDR)];
        end
    end

    // Read shifter: loaded after the command byte, shifted on falling SCLK
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_shift_q <= 32'h0000_0000;
        end else if (cs_n_i) begin
            rd_shift_q <= 32'h0000_0000;
        end else if (rd_load) begin
            rd_shift_q <= rd_mux;
        end else if (sclk_fall && bit_cnt_q > CMD_DONE_CNT) begin
            rd_shift_q <= {rd_shift_q[DATA_BITS-2:0], 1'b0};
        end
    end
    assign miso_o = rd_shift_q[DATA_BITS-1];

    // ------------------------------------------------------------
    // Channel pairing and drive decode
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] on_d;
    logic [NUM_CH-1:0] drive_on_q;
    logic [1:0] bridge01_q;
    logic [1:0] bridge23_q;
    chan_cfg_type [NUM_CH-1:0] cfg_d;
    chan_cfg_type [NUM_CH-1:0] drive_cfg_q;

    // Mode decode; reserved mode behaves as independent
    always_comb begin
        on_d = channel_on_q;
        cfg_d = cfg_q;
        case (pair01_q)
            MODE_PARALLEL: begin
                on_d[1] = channel_on_q[0];
                cfg_d[1] = cfg_q[0];
            end
            MODE_HBRIDGE: begin
                on_d[1:0] = {2{channel_on_q[1:0] != BRIDGE_HIZ}};
                cfg_d[1] = cfg_q[0];
            end
            default: begin
            end
        endcase
        case (pair23_q)
            MODE_PARALLEL: begin
                on_d[3] = channel_on_q[2];
                cfg_d[3] = cfg_q[2];
            end
            MODE_HBRIDGE: begin
                on_d[3:2] = {2{channel_on_q[3:2] != BRIDGE_HIZ}};
                cfg_d[3] = cfg_q[2];
            end
            default: begin
            end
        endcase
        if (!active_q) begin
            on_d = '0;
        end
    end

    // Registered drive outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_on_q <= 8'h00;
            drive_cfg_q <= {NUM_CH{CFG_RESET}};
            bridge01_q <= BRIDGE_HIZ;
            bridge23_q <= BRIDGE_HIZ;
        end else begin
            drive_on_q <= on_d;
            drive_cfg_q <= cfg_d;
            bridge01_q <= (active_q && pair01_q == MODE_HBRIDGE) ?
                channel_on_q[1:0] : BRIDGE_HIZ;
            bridge23_q <= (active_q && pair23_q == MODE_HBRIDGE) ?
                channel_on_q[3:2] : BRIDGE_HIZ;
        end
    end
    assign drive_on_o = drive_on_q;
    assign drive_cfg_o = drive_cfg_q;
    assign bridge01_o = bridge01_q;
    assign bridge23_o = bridge23_q;

    // ------------------------------------------------------------
    // Main oscillator, chopping and excitation timing
    // ------------------------------------------------------------
    logic [10:0] osc_cnt_q;
    logic osc_tick;

    // Main oscillator tick derived by division; free running
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_cnt_q <= 11'h000;
        end else if (osc_tick) begin
            osc_cnt_q <= 11'h000;
        end else begin
            osc_cnt_q <= osc_cnt_q + 11'h001;
        end
    end
    assign osc_tick = osc_cnt_q == 11'(OSC_DIV_CYCLES - 1);

    logic [NUM_CH-1:0] excite_q;
    logic [NUM_CH-1:0] drive_on_prev_q;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        logic [1:0] chop_cnt_q;
        logic [1:0] chop_last;
        logic chop_tick;
        logic [HIT_CNT_W-1:0] hit_cnt_q;
        logic [7:0] hit_time;

        assign hit_time = drive_cfg_q[ch].hit_time;
        // Divide by 4, 3, 2, 1 for codes 0..3
        assign chop_last = 2'h3 - drive_cfg_q[ch].chop_divider;
        assign chop_tick = osc_tick && (chop_cnt_q >= chop_last);
        assign chop_tick_o[ch] = chop_tick;

        // Chopping divider; restarts cleanly if the code grows mid-count
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                chop_cnt_q <= 2'h0;
            end else if (chop_tick) begin
                chop_cnt_q <= 2'h0;
            end else if (osc_tick) begin
                chop_cnt_q <= chop_cnt_q + 2'h1;
            end
        end

        // Excitation phase counted in chop periods from switch-on
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                hit_cnt_q <= '0;
            end else if (!drive_on_q[ch]) begin
                hit_cnt_q <= '0;
            end else if (!drive_on_prev_q[ch]) begin
                hit_cnt_q <= HIT_CNT_W'(hit_time * HIT_PERIODS_PER_LSB);
            end else if (chop_tick && hit_cnt_q != '0) begin
                hit_cnt_q <= hit_cnt_q - 1'b1;
            end
        end

        // Continuous excitation ignores the counter; zero time never excites
        always_comb begin
            if (!drive_on_q[ch] || hit_time == HIT_NONE) begin
                excite_q[ch] = 1'b0;
            end else if (hit_time == HIT_CONTINUOUS) begin
                excite_q[ch] = 1'b1;
            end else begin
                excite_q[ch] = !drive_on_prev_q[ch] || hit_cnt_q != '0;
            end
        end
    end

    // Switch-on history for the excitation start
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_on_prev_q <= 8'h00;
        end else begin
            drive_on_prev_q <= drive_on_q;
        end
    end
    assign excite_o = excite_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_status_write;
        wr_commit && addr == STATUS_ADDR;
    endsequence

    property p_pair01_guard;
        s_status_write and (channel_on_q[1:0] != 2'b00) |=> $stable(pair01_q);
    endproperty
    a_pair01_guard: assert property (p_pair01_guard) else $error("pair01 changed while on");

    property p_pair23_guard;
        s_status_write and (channel_on_q[3:2] != 2'b00) |=> $stable(pair23_q);
    endproperty
    a_pair23_guard: assert property (p_pair23_guard) else $error("pair23 changed while on");

    property p_parallel01;
        active_q && pair01_q == MODE_PARALLEL |=> drive_on_q[1] == $past(channel_on_q[0]);
    endproperty
    a_parallel01: assert property (p_parallel01) else $error("parallel follower wrong");

    property p_bridge_hiz;
        active_q && pair23_q == MODE_HBRIDGE && channel_on_q[3:2] == 2'b00
            |=> drive_on_q[3:2] == 2'b00 && bridge23_o == BRIDGE_HIZ;
    endproperty
    a_bridge_hiz: assert property (p_bridge_hiz) else $error("hi-z bridge still driven");

    property p_thermal;
        ##1 status_rd[THERMAL_POS] == $past(thermal_i);
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal flag mismatch");

    property p_comm_error;
        wr_error |=> comm_error_q ##1 comm_error_q;
    endproperty
    a_comm_error: assert property (p_comm_error) else $error("comm error not held");

    property p_low_power;
        !active_q ##1 !active_q |-> drive_on_q == 8'h00 && excite_o == 8'h00;
    endproperty
    a_low_power: assert property (p_low_power) else $error("outputs on in low power");

    property p_cfg_write;
        wr_commit && addr == CFG_FIRST_ADDR |=> cfg_q[0] == $past(wdata_q);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_vdr_no_miss;
        cfg_q[3].regulation_select && fault_i.excite_miss == 8'h08
            |=> !flags_q[EXCITE_MISS_POS];
    endproperty
    a_vdr_no_miss: assert property (p_vdr_no_miss) else $error("voltage channel miss flagged");

endmodule : solenoid_driver_status_config_regs

//--- tb/tb_top.sv
// Self-checking bench for the solenoid driver status and config register bank
`timescale 1ns/10ps
module tb_top;
    import solenoid_regs_pkg::*;

    // ----------------------------------------
    // Stimulus, observed outputs, counters
    // ----------------------------------------
    logic clk_i, nrst_i, cs_n_i, sclk_i, mosi_i, thermal_i, undervolt_event_i;
    chan_fault_type fault_i;
    logic miso_o;
    logic [NUM_CH-1:0] drive_on_o;
    logic [1:0] bridge01_o;
    logic [1:0] bridge23_o;
    logic [NUM_CH-1:0] excite_o;
    logic [NUM_CH-1:0] chop_tick_o;
    chan_cfg_type [NUM_CH-1:0] drive_cfg_o;
    int n_errors = 0;
    int tests_run = 0;
    logic [31:0] v;

    solenoid_driver_status_config_regs uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
        .mosi_i(mosi_i), .miso_o(miso_o), .thermal_i(thermal_i),
        .undervolt_event_i(undervolt_event_i), .fault_i(fault_i),
        .drive_on_o(drive_on_o), .excite_o(excite_o), .chop_tick_o(chop_tick_o),
        .bridge01_o(bridge01_o), .bridge23_o(bridge23_o), .drive_cfg_o(drive_cfg_o)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Inputs always move 1 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Cycles between two chop ticks of one channel
    task automatic chop_period(input int ch, input int exp);
        int n;
        n = 0;
        while (chop_tick_o[ch] !== 1'b1) step(1);
        step(1);
        while (chop_tick_o[ch] !== 1'b1) begin
            step(1);
            n++;
        end
        chk(32'(n + 1), 32'(exp));
    endtask : chop_period

    // One 40-bit frame; 3 clk per phase keeps margin over the 2-cycle minimum
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, output logic [31:0] rd);
        logic [39:0] f;
        f = {cmd, wd};
        rd = '0;
        cs_n_i = 1'b0;
        for (int i = 0; i < 40; i++) begin
            mosi_i = f[39-i];
            step(3);
            sclk_i = 1'b1;
            if (i >= 8) rd[39-i] = miso_o;
            step(3);
            sclk_i = 1'b0;
        end
        step(2);
        cs_n_i = 1'b1;
        step(4);
    endtask : xfer

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer({4'h8, a}, d, v);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        xfer({4'h0, a}, 32'h0000_0000, v);
        chk(v, exp);
    endtask : rdc

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // Watchdog: about 60 frames, two chop periods and a 52k wait, near 80k cycles
    initial begin
        repeat (95000) @(posedge clk_i);
        n_errors++;
        conclude();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst_i = 1'b0; cs_n_i = 1'b1; sclk_i = 1'b0; mosi_i = 1'b0;
        thermal_i = 1'b0; undervolt_event_i = 1'b0; fault_i = '0;
        step(6);
        nrst_i = 1'b1;
        step(3);
        rdc(4'h0, 32'h0000_0002);
        rdc(4'h0, 32'h0000_0000);
        $display("test reset done");
        // Low byte keeps bit 7 clear so channel 3 counts excitation misses later
        for (int i = 1; i <= 8; i++) rdc(4'(i), CFG_RESET);
        for (int i = 1; i <= 8; i++) wr(4'(i), 32'h5A3C_9070 | 32'(i));
        for (int i = 1; i <= 8; i++) rdc(4'(i), 32'h5A3C_9070 | 32'(i));
        for (int i = 0; i < 8; i++) chk(drive_cfg_o[i], 32'h5A3C_9071 + 32'(i));
        $display("test config done");
        rdc(4'h9, 32'h0000_0000);
        wr(4'h9, 32'hFFFF_FFFF);
        rdc(4'h0, 32'h0000_0004);
        $display("test unmapped done");
        // Channel 3 of each fault kind: plunger, excite, open load, overcurrent
        for (int k = 0; k < 4; k++) begin
            fault_i = 32'h0000_0008 << (8 * k);
            step(2);
            rdc(4'h0, 32'h0000_0008 << k);
        end
        wr(4'h4, 32'h0000_0080);
        fault_i = 32'h0000_0800;
        step(2);
        rdc(4'h0, 32'h0000_0000);
        fault_i = '0;
        thermal_i = 1'b1;
        step(2);
        rdc(4'h0, 32'h0000_0080);
        thermal_i = 1'b0;
        undervolt_event_i = 1'b1;
        step(1);
        undervolt_event_i = 1'b0;
        rdc(4'h0, 32'h0000_0002);
        $display("test flags done");
        wr(4'h4, 32'h0000_0000);
        chop_period(3, 4 * OSC_DIV_CYCLES);
        chop_period(0, OSC_DIV_CYCLES);
        wr(4'h0, 32'h0000_0601);
        rdc(4'h0, 32'h0000_0601);
        for (int s = 0; s < 4; s++) begin
            wr(4'h0, 32'h0000_0601 | (32'(s) << 24));
            chk(32'(bridge01_o), 32'(s));
        end
        // Pair 0/1 is on, so its mode change must be ignored
        wr(4'h0, 32'h0400_0401);
        rdc(4'h0, 32'h0400_0601);
        chk(32'(drive_on_o[3:2]), 32'h0000_0003);
        chk(drive_cfg_o[3], 32'h5A3C_9073);
        wr(4'h0, 32'h0400_0001);
        rdc(4'h0, 32'h0400_0401);
        wr(4'h0, 32'h0400_0400);
        chk(32'(drive_on_o), 32'h0000_0000);
        $display("test pair modes done");
        // Both pairs off first, then pair 0/1 parallel and pair 2/3 H-bridge
        wr(4'h0, 32'h0000_0000);
        wr(4'h0, 32'h0000_0901);
        rdc(4'h0, 32'h0000_0901);
        wr(4'h0, 32'h0900_0901);
        chk(32'(drive_on_o), 32'h0000_000F);
        chk(32'(bridge23_o), 32'h0000_0002);
        chk(drive_cfg_o[1], 32'h5A3C_9071);
        chk(drive_cfg_o[3], 32'h5A3C_9073);
        wr(4'h0, 32'h0100_0901);
        chk(32'(drive_on_o), 32'h0000_0003);
        chk(32'(bridge23_o), 32'h0000_0000);
        $display("test parallel and bridge done");
        // Channel 4 never excites, 5 continuous, 6 for 40 chop periods
        wr(4'h5, 32'h0000_0000);
        wr(4'h6, 32'h0000_FF00);
        wr(4'h7, 32'h0000_0130);
        wr(4'h0, 32'h7100_0901);
        chk(32'(excite_o), 32'h0000_0063);
        step(48000);
        chk(32'(excite_o), 32'h0000_0063);
        step(4000);
        chk(32'(excite_o), 32'h0000_0023);
        $display("test excitation done");
        conclude();
    end
endmodule : tb_top
